// ### inc/pm_seq_defines.svh
`ifndef PM_SEQ_DEFINES_SVH
`define PM_SEQ_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_PLL_CFG 8'h04
`define OFS_CLK_DIV 8'h08
`define OFS_PMODE 8'h0C
`define OFS_PGATE 8'h10
`define OFS_PDIV 8'h14
`define OFS_STATUS 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_PLL_EN 0
`define CTRL_PLL_CONN 1
`define CTRL_SRC_LO 2
`define CTRL_SRC_HI 3
`define CTRL_MAIN_EN 4
`define CFG_N_HI 7
`define CFG_M_LO 8
`define CFG_M_HI 22

// ----------------------------------------
// mode request codes and clock sources
// ----------------------------------------
`define PMODE_IDLE 3'h1
`define PMODE_SLEEP 3'h2
`define PMODE_PDOWN 3'h3
`define PMODE_DEEP 3'h4
`define SRC_RC 2'h0
`define SRC_MAIN 2'h1

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RST 5'h00
`define PLL_CFG_RST 23'h00_0000
`define CLK_DIV_RST 16'h0000
`define PGATE_RST 8'hFF
`define PDIV_RST 16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 25
`define RC_MHZ 4
`define RC_START_US 60
`define FLASH_START_US 100
`define RC_START_CLKS (`RC_START_US * `CLK_MHZ)
`define FLASH_TICKS (`FLASH_START_US * `RC_MHZ)
`define RESUME_RC_TICKS 4
`define RESUME_MAIN_TICKS 4096
`define RST_HOLD_CLKS 16

`endif

// ### inc/pm_seq_pkg.sv
package pm_seq_pkg;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_RUN,
    ST_IDLE,
    ST_SLEEP,
    ST_PDOWN,
    ST_DEEP,
    ST_OSC_START,
    ST_RESUME
  } pm_state_t;

endpackage : pm_seq_pkg

// ### core/power_mode_clock_sequencer.sv
`timescale 1ns/10ps
`include "pm_seq_defines.svh"

// Functional notes
// - input pre-divider N from 1 to 256
// - feedback divider M 1..32768, phase compare
// - reset and power-down: synthesizer off, bypassed
// - power-up and deep wakes run from RC
// - power-down wake always passes wake timer
// - idle stops processor until interrupt or reset
// - sleep stops clocks, keeps state, rtc runs
// - sleep gates RC output, RC stays powered
// - sleep clears synthesizer and clock dividers
// - sleep ends on clockless interrupt; flash on
// - sleep resume after 4 or 4096 cycles
// - power-down also stops RC and flash
// - RC start 60 us, then 4 cycles
// - flash counter 100 us, blocks flash access
// - deep mode: regulator off, full reset resume
// - deep mode wakes on alarm or reset
// - per-peripheral clock gate and divider
// - battery domain alarm output drives power-up
// - reset held for osc, count, flash init
module power_mode_clock_sequencer
  import pm_seq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_ref_tick,
  input wire logic i_osc_tick,
  input wire logic i_pll_lock,
  input wire logic i_rc_tick,
  input wire logic i_main_tick,
  input wire logic i_rc_ok,
  input wire logic i_irq,
  input wire logic i_wake_irq,
  input wire logic i_rtc_alarm,
  output logic o_sys_rst_n,
  output logic o_pll_power,
  output logic o_pll_connect,
  output logic o_pfd_up,
  output logic o_pfd_down,
  output logic [1:0] o_clk_src,
  output logic [7:0] o_cpu_div,
  output logic [7:0] o_usb_div,
  output logic o_cpu_clk_en,
  output logic o_rc_power,
  output logic o_rc_out_en,
  output logic o_main_osc_en,
  output logic o_flash_power,
  output logic o_flash_access,
  output logic o_regulator_on,
  output logic o_alarm_out,
  output logic [7:0] o_pclk_tick
);

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  pm_state_t st_reg;
  pm_state_t st_next;
  logic [4:0] ctrl_reg;
  logic [22:0] pll_cfg_reg;
  logic [15:0] clk_div_reg;
  logic [7:0] pgate_reg;
  logic [15:0] pdiv_reg;
  logic [10:0] cnt_reg;
  logic [12:0] wake_cnt_reg;
  logic [8:0] flash_cnt_reg;
  logic flash_busy_reg;
  logic resume_main_reg;
  logic [7:0] pre_cnt_reg;
  logic [14:0] fb_cnt_reg;
  logic ref_div_reg;
  logic fb_div_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [2:0] mode_req;
  logic req;
  logic wr;
  logic [31:0] wmask;
  logic enter_sleep;
  logic enter_pd;
  logic cfg_clr;
  logic flash_start;
  logic run_like;
  logic sel_tick;
  logic [12:0] resume_last;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign req = i_wb_cyc & i_wb_stb;
  assign wr = req & i_wb_we & ~ack_reg;
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                  {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  // bytes without a strobe keep their value
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (i_wb_dat & wmask);
  endfunction : merge

  assign mode_req = (wr && i_wb_adr == `OFS_PMODE && i_wb_sel[0])
                    ? i_wb_dat[2:0] : 3'h0;
  assign run_like = (st_reg == ST_RUN) || (st_reg == ST_IDLE);
  assign enter_sleep = (st_reg == ST_RUN) &&
                       (mode_req == `PMODE_SLEEP);
  assign enter_pd = (st_reg == ST_RUN) &&
                    ((mode_req == `PMODE_PDOWN) ||
                     (mode_req == `PMODE_DEEP));
  // nothing survives the logic supply going away
  assign cfg_clr = (st_reg == ST_DEEP) && i_rtc_alarm;

  // single wait state answer, unmapped reads zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg) begin
      rdat_reg <= 32'h0000_0000;
      if (i_wb_adr == `OFS_CTRL) begin
        rdat_reg[4:0] <= ctrl_reg;
      end else if (i_wb_adr == `OFS_PLL_CFG) begin
        rdat_reg[22:0] <= pll_cfg_reg;
      end else if (i_wb_adr == `OFS_CLK_DIV) begin
        rdat_reg[15:0] <= clk_div_reg;
      end else if (i_wb_adr == `OFS_PGATE) begin
        rdat_reg[7:0] <= pgate_reg;
      end else if (i_wb_adr == `OFS_PDIV) begin
        rdat_reg[15:0] <= pdiv_reg;
      end else if (i_wb_adr == `OFS_STATUS) begin
        rdat_reg[2:0] <= st_reg;
        rdat_reg[3] <= i_pll_lock;
        rdat_reg[4] <= o_pll_connect;
        rdat_reg[5] <= o_flash_access;
        rdat_reg[6] <= resume_main_reg;
      end
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg <= `CTRL_RST;
    end else if (cfg_clr) begin
      ctrl_reg <= `CTRL_RST;
    end else if (enter_pd) begin
      ctrl_reg <= `CTRL_RST;
    end else if (enter_sleep) begin
      ctrl_reg[`CTRL_PLL_EN] <= 1'b0;
      ctrl_reg[`CTRL_PLL_CONN] <= 1'b0;
    end else if (wr && i_wb_adr == `OFS_CTRL) begin
      ctrl_reg <= 5'(merge({27'h000_0000,
                            ctrl_reg}));
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pll_cfg_reg <= `PLL_CFG_RST;
    end else if (cfg_clr) begin
      pll_cfg_reg <= `PLL_CFG_RST;
    end else if (wr && i_wb_adr == `OFS_PLL_CFG) begin
      pll_cfg_reg <= 23'(merge({9'h000, pll_cfg_reg}));
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_div_reg <= `CLK_DIV_RST;
    end else if (cfg_clr || enter_sleep || enter_pd) begin
      clk_div_reg <= `CLK_DIV_RST;
    end else if (wr && i_wb_adr == `OFS_CLK_DIV) begin
      clk_div_reg <= 16'(merge({16'h0000, clk_div_reg}));
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pgate_reg <= `PGATE_RST;
      pdiv_reg <= `PDIV_RST;
    end else if (cfg_clr) begin
      pgate_reg <= `PGATE_RST;
      pdiv_reg <= `PDIV_RST;
    end else if (wr && i_wb_adr == `OFS_PGATE) begin
      pgate_reg <= 8'(merge({24'h00_0000, pgate_reg}));
    end else if (wr && i_wb_adr == `OFS_PDIV) begin
      pdiv_reg <= 16'(merge({16'h0000, pdiv_reg}));
    end
  end

  // ----------------------------------------
  // power mode sequencer
  // ----------------------------------------
  assign sel_tick = resume_main_reg ? i_main_tick : i_rc_tick;
  assign resume_last = resume_main_reg
                       ? 13'(`RESUME_MAIN_TICKS - 1)
                       : 13'(`RESUME_RC_TICKS - 1);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_RESET: begin
        // hold until osc, count, flash done
        if (i_rc_ok && !flash_busy_reg &&
            cnt_reg >= 11'(`RST_HOLD_CLKS)) begin
          st_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (mode_req == `PMODE_IDLE) begin
          st_next = ST_IDLE;
        end else if (mode_req == `PMODE_SLEEP) begin
          st_next = ST_SLEEP;
        end else if (mode_req == `PMODE_PDOWN) begin
          st_next = ST_PDOWN;
        end else if (mode_req == `PMODE_DEEP) begin
          st_next = ST_DEEP;
        end
      end
      ST_IDLE: begin
        if (i_irq) begin
          st_next = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (i_wake_irq) begin
          st_next = ST_RESUME;
        end
      end
      ST_PDOWN: begin
        if (i_wake_irq) begin
          st_next = ST_OSC_START;
        end
      end
      ST_DEEP: begin
        if (i_rtc_alarm) begin
          st_next = ST_RESET;
        end
      end
      ST_OSC_START: begin
        if (cnt_reg == 11'(`RC_START_CLKS - 1)) begin
          st_next = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (sel_tick && wake_cnt_reg == resume_last) begin
          st_next = ST_RUN;
        end
      end
      default: begin
        st_next = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // which oscillator the resume count watches
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      resume_main_reg <= 1'b0;
    end else if (enter_sleep) begin
      resume_main_reg <= (ctrl_reg[`CTRL_SRC_HI:`CTRL_SRC_LO]
                          == `SRC_MAIN);
    end else if (enter_pd) begin
      resume_main_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= 11'h000;
    end else if (st_next != st_reg) begin
      cnt_reg <= 11'h000;
    end else if (cnt_reg != 11'h7FF) begin
      cnt_reg <= cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wake_cnt_reg <= 13'h0000;
    end else if (st_reg != ST_RESUME) begin
      wake_cnt_reg <= 13'h0000;
    end else if (sel_tick) begin
      wake_cnt_reg <= wake_cnt_reg + 13'h0001;
    end
  end

  // ----------------------------------------
  // flash wake-up counter
  // ----------------------------------------
  assign flash_start = ((st_reg == ST_OSC_START) &&
                        (st_next == ST_RESUME)) ||
                       ((st_reg == ST_DEEP) &&
                        (st_next == ST_RESET));

  // count RC ticks for flash start-up
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flash_busy_reg <= 1'b1;
      flash_cnt_reg <= 9'h000;
    end else if (flash_start) begin
      flash_busy_reg <= 1'b1;
      flash_cnt_reg <= 9'h000;
    end else if (enter_pd) begin
      flash_busy_reg <= 1'b1;
      flash_cnt_reg <= 9'h000;
    end else if (flash_busy_reg && o_rc_power &&
                 st_reg != ST_PDOWN && i_rc_tick) begin
      if (flash_cnt_reg == 9'(`FLASH_TICKS - 1)) begin
        flash_busy_reg <= 1'b0;
      end
      flash_cnt_reg <= flash_cnt_reg + 9'h001;
    end
  end

  // ----------------------------------------
  // synthesizer dividers and phase compare
  // ----------------------------------------
  // input divide by N
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_cnt_reg <= 8'h00;
      ref_div_reg <= 1'b0;
    end else if (!o_pll_power) begin
      pre_cnt_reg <= 8'h00;
      ref_div_reg <= 1'b0;
    end else begin
      ref_div_reg <= 1'b0;
      if (i_ref_tick) begin
        if (pre_cnt_reg == pll_cfg_reg[`CFG_N_HI:0]) begin
          pre_cnt_reg <= 8'h00;
          ref_div_reg <= 1'b1;
        end else begin
          pre_cnt_reg <= pre_cnt_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fb_cnt_reg <= 15'h0000;
      fb_div_reg <= 1'b0;
    end else if (!o_pll_power) begin
      fb_cnt_reg <= 15'h0000;
      fb_div_reg <= 1'b0;
    end else begin
      fb_div_reg <= 1'b0;
      if (i_osc_tick) begin
        if (fb_cnt_reg ==
            pll_cfg_reg[`CFG_M_HI:`CFG_M_LO]) begin
          fb_cnt_reg <= 15'h0000;
          fb_div_reg <= 1'b1;
        end else begin
          fb_cnt_reg <= fb_cnt_reg + 15'h0001;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pfd_up <= 1'b0;
      o_pfd_down <= 1'b0;
    end else if (!o_pll_power) begin
      o_pfd_up <= 1'b0;
      o_pfd_down <= 1'b0;
    end else if ((o_pfd_up | ref_div_reg) &&
                 (o_pfd_down | fb_div_reg)) begin
      o_pfd_up <= 1'b0;
      o_pfd_down <= 1'b0;
    end else begin
      o_pfd_up <= o_pfd_up | ref_div_reg;
      o_pfd_down <= o_pfd_down | fb_div_reg;
    end
  end

  // ----------------------------------------
  // clock and power outputs
  // ----------------------------------------
  // off and bypassed outside run modes
  assign o_pll_power = ctrl_reg[`CTRL_PLL_EN] & run_like;
  assign o_pll_connect = o_pll_power & i_pll_lock &
                         ctrl_reg[`CTRL_PLL_CONN];
  assign o_clk_src = ctrl_reg[`CTRL_SRC_HI:`CTRL_SRC_LO];
  assign o_cpu_div = clk_div_reg[7:0];
  assign o_usb_div = clk_div_reg[15:8];
  assign o_cpu_clk_en = (st_reg == ST_RUN);
  // sleep gates RC, keeps it powered
  assign o_rc_out_en = run_like || (st_reg == ST_RESET) ||
                        (st_reg == ST_RESUME);
  assign o_rc_power = (st_reg != ST_PDOWN) &&
                      (st_reg != ST_DEEP);
  assign o_flash_power = o_rc_power;
  assign o_main_osc_en = ctrl_reg[`CTRL_MAIN_EN] &&
                         (run_like || (st_reg == ST_RESUME));
  assign o_flash_access = o_flash_power & ~flash_busy_reg;
  assign o_regulator_on = (st_reg != ST_DEEP);
  assign o_sys_rst_n = (st_reg != ST_RESET) &&
                       (st_reg != ST_DEEP);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_alarm_out <= 1'b0;
    end else begin
      o_alarm_out <= i_rtc_alarm;
    end
  end

  // ----------------------------------------
  // peripheral clock gates and dividers
  // ----------------------------------------
  // divide by 1, 2, 4 or 8; idle keeps them going
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pclk
      logic [2:0] pcnt_reg;
      logic [2:0] plast;
      assign plast = 3'((4'h1 << pdiv_reg[2*gi +: 2]) - 4'h1);
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          pcnt_reg <= 3'h0;
          o_pclk_tick[gi] <= 1'b0;
        end else if (!run_like || !pgate_reg[gi]) begin
          pcnt_reg <= 3'h0;
          o_pclk_tick[gi] <= 1'b0;
        end else if (pcnt_reg >= plast) begin
          pcnt_reg <= 3'h0;
          o_pclk_tick[gi] <= 1'b1;
        end else begin
          pcnt_reg <= pcnt_reg + 3'h1;
          o_pclk_tick[gi] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : power_mode_clock_sequencer

// ### tb/pmcs_sva.sv
`timescale 1ns/10ps
// ----------------------------------------
// port checker for the power sequencer
// ----------------------------------------
module pmcs_sva (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_rc_ok,
  input wire logic i_rtc_alarm,
  input wire logic o_wb_ack,
  input wire logic o_sys_rst_n,
  input wire logic o_pll_power,
  input wire logic o_pll_connect,
  input wire logic o_cpu_clk_en,
  input wire logic o_rc_power,
  input wire logic o_rc_out_en,
  input wire logic o_flash_power,
  input wire logic o_flash_access,
  input wire logic o_regulator_on,
  input wire logic o_alarm_out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_ack_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence

  a_ack_one_pulse: assert property (s_req |=> s_ack_pulse)
    else $error("bus ack not a single pulse after request");
  a_ack_needs_req: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("bus ack without request");
  a_cpu_held_reset: assert property (!o_sys_rst_n |-> !o_cpu_clk_en)
    else $error("processor clock runs during reset");
  a_pll_off_reset: assert property (
    !o_sys_rst_n |-> !o_pll_power && !o_pll_connect)
    else $error("synthesizer active during reset");
  a_reset_needs_osc: assert property (
    $rose(o_sys_rst_n) |-> $past(i_rc_ok))
    else $error("reset released without running oscillator");
  a_rc_gate_out: assert property (!o_rc_power |-> !o_rc_out_en)
    else $error("rc output enabled while rc off");
  a_flash_gate: assert property (!o_flash_power |-> !o_flash_access)
    else $error("flash access while flash off");
  a_regulator_deep: assert property (!o_regulator_on |-> !o_sys_rst_n)
    else $error("logic runs with regulator off");
  a_alarm_copy: assert property (o_alarm_out == $past(i_rtc_alarm))
    else $error("alarm output does not follow rtc alarm");
endmodule : pmcs_sva

bind power_mode_clock_sequencer pmcs_sva chk_i (.i_clk, .i_rstn, .i_wb_cyc,
  .i_wb_stb, .i_rc_ok, .i_rtc_alarm, .o_wb_ack, .o_sys_rst_n, .o_pll_power,
  .o_pll_connect, .o_cpu_clk_en, .o_rc_power, .o_rc_out_en, .o_flash_power,
  .o_flash_access, .o_regulator_on, .o_alarm_out);

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  import pm_seq_pkg::*;
  logic i_clk, i_rstn, cyc, stb, we, rc_t, ref_t, osc_t, lock, irq, wk, alarm;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, q, o_wb_dat;
  logic o_wb_ack, o_sys_rst_n, o_pll_power, o_pll_connect, o_pfd_up;
  logic o_pfd_down, o_cpu_clk_en, o_rc_power, o_rc_out_en, o_main_osc_en;
  logic o_flash_power, o_flash_access, o_regulator_on, o_alarm_out;
  logic [1:0] o_clk_src;
  logic [7:0] o_cpu_div, o_usb_div, o_pclk_tick;
  logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C};
  logic [31:0] rv [7] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_00FF, 32'h0000_0000, 32'h0000_0021, 32'h0000_0000};
  int errors, num_checks, n, m;

  power_mode_clock_sequencer power_mode_clock_sequencer_i (.i_clk, .i_rstn,
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat, .o_wb_ack,
    .i_ref_tick(ref_t), .i_osc_tick(osc_t), .i_pll_lock(lock),
    .i_rc_tick(rc_t), .i_main_tick(1'b1), .i_rc_ok(1'b1), .i_irq(irq),
    .i_wake_irq(wk), .i_rtc_alarm(alarm), .o_sys_rst_n, .o_pll_power,
    .o_pll_connect, .o_pfd_up, .o_pfd_down, .o_clk_src, .o_cpu_div,
    .o_usb_div, .o_cpu_clk_en, .o_rc_power, .o_rc_out_en, .o_main_osc_en,
    .o_flash_power, .o_flash_access, .o_regulator_on, .o_alarm_out,
    .o_pclk_tick);

  // ----------------------------------------
  // clock and rc tick at half rate
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    rc_t <= ~rc_t;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // classic cycle: hold until ack sampled, then release
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    // look after the edge so a launching edge is never mistaken
    do begin
      @(posedge i_clk);
      #1;
    end while (o_wb_ack !== 1'b1);
    q = o_wb_dat;
    @(posedge i_clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask : rd

  task automatic pulse(input int k);
    @(posedge i_clk);
    if (k == 0) irq <= 1'b1;
    else if (k == 1) wk <= 1'b1;
    else alarm <= 1'b1;
    @(posedge i_clk);
    irq <= 1'b0;
    wk <= 1'b0;
    alarm <= 1'b0;
  endtask : pulse

  // n counts rc ticks, m counts clocks (main tick every clock)
  task automatic wait_run(input int lim);
    n = 0;
    m = 0;
    do begin
      @(posedge i_clk);
      n += rc_t;
      m++;
      #1;
    end while (o_cpu_clk_en !== 1'b1 && m < lim);
  endtask : wait_run

  task automatic wait_rst();
    n = 0;
    while (o_sys_rst_n !== 1'b1 && n < 3000) begin
      @(posedge i_clk);
      n++;
      #1;
    end
  endtask : wait_rst

  task automatic count_out(input int sel_pfd);
    n = 0;
    m = 0;
    repeat (40) begin
      @(posedge i_clk);
      n += sel_pfd ? o_pfd_up : o_pclk_tick[0];
      m += sel_pfd ? o_pfd_down : |o_pclk_tick[7:1];
    end
  endtask : count_out

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    #1000000;
    errors++;
    report_and_stop();
  end

  initial begin
    i_rstn = 1'b0;
    {cyc, stb, we, rc_t, ref_t, osc_t, lock, irq, wk, alarm} = '0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    errors = 0;
    num_checks = 0;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    wait_rst();
    chk(n >= 799, 1);
    chk(o_pll_power | o_pll_connect, 0);
    chk(o_clk_src, 0);
    foreach (ofs[i]) rd(ofs[i], rv[i]);
    xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000);
    xfer(1'b1, 8'h04, 32'h0000_0201);
    rd(8'h04, 32'h0000_0201);
    xfer(1'b1, 8'h00, 32'h0000_0001);
    chk(o_pll_power, 1);
    lock <= 1'b1;
    xfer(1'b1, 8'h00, 32'h0000_0003);
    chk(o_pll_connect, 1);
    ref_t <= 1'b1;
    count_out(1);
    chk(n > 0 && m == 0, 1);
    ref_t <= 1'b0;
    osc_t <= 1'b1;
    // latched up flag clears on the first feedback pulse
    repeat (8) @(posedge i_clk);
    count_out(1);
    chk(m > 0 && n == 0, 1);
    osc_t <= 1'b0;
    xfer(1'b1, 8'h10, 32'h0000_0001);
    count_out(0);
    chk(n > 0 && m == 0, 1);
    xfer(1'b1, 8'h10, 32'h0000_0000);
    count_out(0);
    chk(n + m, 0);
    xfer(1'b1, 8'h0C, 32'h0000_0001);
    chk(o_cpu_clk_en, 0);
    xfer(1'b1, 8'h0C, 32'h0000_0002);
    xfer(1'b0, 8'h18, 32'h0000_0000);
    chk(q[2:0], 2);
    pulse(0);
    wait_run(20);
    chk(o_cpu_clk_en, 1);
    xfer(1'b1, 8'h08, 32'h0000_1234);
    chk({o_usb_div, o_cpu_div}, 32'h0000_1234);
    xfer(1'b1, 8'h0C, 32'h0000_0002);
    chk({o_usb_div, o_cpu_div}, 0);
    chk({o_rc_power, o_rc_out_en, o_flash_power}, 3'h5);
    chk({o_cpu_clk_en, o_pll_power, o_pll_connect}, 0);
    rd(8'h00, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    pulse(1);
    wait_run(100);
    chk(n, 4);
    xfer(1'b1, 8'h00, 32'h0000_0014);
    chk(o_main_osc_en, 1);
    xfer(1'b1, 8'h0C, 32'h0000_0002);
    chk(o_main_osc_en, 0);
    pulse(1);
    wait_run(5000);
    chk(m, 4096);
    xfer(1'b1, 8'h00, 32'h0000_0000);
    xfer(1'b1, 8'h0C, 32'h0000_0002);
    pulse(1);
    wait_run(100);
    chk(n, 4);
    xfer(1'b1, 8'h00, 32'h0000_0001);
    xfer(1'b1, 8'h0C, 32'h0000_0003);
    chk({o_pll_power, o_rc_power, o_flash_power}, 0);
    pulse(1);
    wait_run(3000);
    chk(m > 1500 && o_flash_access === 1'b0, 1);
    chk(o_clk_src, 0);
    n = 0;
    m = 0;
    while (o_flash_access !== 1'b1 && m < 2000) begin
      @(posedge i_clk);
      n += rc_t;
      m++;
      #1;
    end
    chk(n, 396);
    xfer(1'b1, 8'h10, 32'h0000_000F);
    xfer(1'b1, 8'h0C, 32'h0000_0004);
    chk({o_regulator_on, o_sys_rst_n}, 0);
    pulse(1);
    chk(o_regulator_on, 0);
    pulse(2);
    #1;
    chk(o_alarm_out, 1);
    wait_rst();
    chk(o_sys_rst_n, 1);
    rd(8'h10, 32'h0000_00FF);
    rd(8'h00, 32'h0000_0000);
    report_and_stop();
  end
endmodule : tb
